//--- logic/rcw_cfg.svh
// constants for the reset cause and wake delay block
// assumes a single 25 MHz core clock
`ifndef RCW_CFG_SVH
`define RCW_CFG_SVH

`define RCW_CLK_PERIOD_NS       40
`define RCW_CPU_START_DELAY_NS  2000
`define RCW_CPU_START_CYC       ((`RCW_CPU_START_DELAY_NS + `RCW_CLK_PERIOD_NS - 1) / `RCW_CLK_PERIOD_NS)
`define RCW_PLL_LOCK_NS         2000000
`define RCW_PLL_LOCK_CYC        ((`RCW_PLL_LOCK_NS + `RCW_CLK_PERIOD_NS - 1) / `RCW_CLK_PERIOD_NS)
`define RCW_FAST_RC_SETTLE_NS   1000000
`define RCW_FAST_RC_SETTLE_CYC  ((`RCW_FAST_RC_SETTLE_NS + `RCW_CLK_PERIOD_NS - 1) / `RCW_CLK_PERIOD_NS)
`define RCW_TMR_W               16

`define RCW_ADDR_RCC            8'h00
`define RCW_ADDR_WCTL           8'h01
`define RCW_ADDR_WSTAT          8'h02

`define RCW_BIT_INT_PRIO        7
`define RCW_BIT_SOFT_BROWNOUT   6
`define RCW_BIT_RESET_INSTR     4
`define RCW_BIT_WDT_EXPIRY      3
`define RCW_BIT_POWERDOWN       2
`define RCW_BIT_POWER_ON        1
`define RCW_BIT_BROWNOUT        0

`define RCW_BROWNOUT_MODE_OFF   2'h0
`define RCW_BROWNOUT_MODE_SW    2'h1
`define RCW_BROWNOUT_MODE_SLEEP 2'h2
`define RCW_BROWNOUT_MODE_HW    2'h3

`define RCW_OSC_SEL_1MHZ        3'h4

`endif

//--- logic/rcw_pkg.sv
// types for the reset cause and wake delay block
// assumes rcw_cfg.svh supplies the timer width
`include "rcw_cfg.svh"
package rcw_pkg;

   typedef enum logic [1:0] {
      SRC_PRIMARY = 2'b00,
      SRC_SLOW    = 2'b01,
      SRC_FAST_RC = 2'b10,
      SRC_NONE    = 2'b11
   } rcw_src_before_t;

   typedef enum logic [2:0] {
      DST_XTAL     = 3'b000,
      DST_XTAL_PLL = 3'b001,
      DST_EXT_RC   = 3'b010,
      DST_SLOW_RC  = 3'b011,
      DST_FAST_RC  = 3'b100
   } rcw_src_after_t;

   typedef enum logic [3:0] {
      CAUSE_NONE        = 4'b0000,
      CAUSE_POWER_ON    = 4'b0001,
      CAUSE_PIN_RUN     = 4'b0010,
      CAUSE_PIN_PM      = 4'b0011,
      CAUSE_WDT         = 4'b0100,
      CAUSE_BROWNOUT    = 4'b0101,
      CAUSE_RESET_INSTR = 4'b0110,
      CAUSE_STACK_FULL  = 4'b0111,
      CAUSE_STACK_UNDER = 4'b1000
   } rcw_cause_t;

   typedef enum logic [1:0] {
      W_RUN  = 2'b00,
      W_HOLD = 2'b01,
      W_PLL  = 2'b10
   } rcw_wake_t;

   typedef struct packed {
      logic           int_priority_enable;
      logic           soft_brownout_enable;
      logic           reset_instr_flag;
      logic           watchdog_expiry_flag;
      logic           powerdown_flag;
      logic           power_on_flag;
      logic           brownout_flag;
      logic [2:0]     osc_sel;
      rcw_cause_t     cause;
      logic           brownout_on;
      rcw_wake_t      wst;
      rcw_src_after_t wake_dst;
      logic           exec_en;
      logic           primary_clock_ready;
      logic           fast_rc_stable_flag;
      logic           ost_pend;
      logic           pll_pend;
      logic           settle_pend;
      logic [7:0]     rdata;
   } rcw_top_st_t;

   typedef struct packed {
      logic [`RCW_TMR_W-1:0] cnt;
   } rcw_tmr_st_t;

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic lvl;
   } rcw_sync_st_t;

endpackage

//--- logic/rcw_sync.sv
// three-stage synchroniser for a level from another clock domain
// assumes the level is slow compared with core_clk_i
`timescale 1ns/1ns
`include "rcw_cfg.svh"
module rcw_sync
   import rcw_pkg::*;
(
   input  wire logic core_clk_i,
   input  wire logic rst_i,
   input  wire logic async_i,
   output logic      level_o
);

   rcw_sync_st_t st_r;
   rcw_sync_st_t st_nxt;

   // output follows only once stages two and three agree
   always_comb begin
      st_nxt     = st_r;
      st_nxt.s1  = async_i;
      st_nxt.s2  = st_r.s1;
      st_nxt.s3  = st_r.s2;
      st_nxt.lvl = (st_r.s2 == st_r.s3) ? st_r.s3 : st_r.lvl;
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign level_o = st_r.lvl;

endmodule

//--- logic/rcw_wake_timer.sv
// down counter that stays busy for a loaded number of cycles
// assumes start_i is a one-cycle pulse on core_clk_i
`timescale 1ns/1ns
`include "rcw_cfg.svh"
module rcw_wake_timer
   import rcw_pkg::*;
(
   input  wire logic                  core_clk_i,
   input  wire logic                  rst_i,
   input  wire logic                  start_i,
   input  wire logic [`RCW_TMR_W-1:0] load_i,
   output logic                       busy_o
);

   rcw_tmr_st_t st_r;
   rcw_tmr_st_t st_nxt;

   // a new start reloads even while counting
   always_comb begin
      st_nxt = st_r;
      if (start_i) begin
         st_nxt.cnt = load_i;
      end else if (st_r.cnt != '0) begin
         st_nxt.cnt = st_r.cnt - `RCW_TMR_W'(1);
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign busy_o = (st_r.cnt != '0);

endmodule

//--- logic/rcw_reset_wake.sv
// reset cause register and wake-up exit delay control
// assumes event inputs are one-cycle pulses on core_clk_i and
// ost_ready_i comes from the oscillator start-up timer domain
//
// Function
// - tell eight reset sources apart
// - low five bits flag reset events
// - hardware clears flags, software sets bits 4, 1 and 0; hardware sets bits 3 and 2
// - all flags readable together in one read
// - priority enable resets 0, software brown-out 1
// - software bit steers brown-out only in mode 01
// - cpu start delay on every wake
// - crystal waits start-up, pll adds lock time
// - fast oscillator settles while code runs
// - oscillator select resets to 1 MHz
// - slow source is the 31 kHz rc
// - power-on clears power-on flag and sets bits 3 and 2
// - brown-out or power-on clears brown-out flag while the detector is on
// - software brown-out bit reads 0 elsewhere
//
// The register addresses and strobed register access were chosen for this implementation.
`timescale 1ns/1ns
`include "rcw_cfg.svh"
module rcw_reset_wake
   import rcw_pkg::*;
#(
   parameter logic [`RCW_TMR_W-1:0] PLL_LOCK_CYC       = `RCW_TMR_W'(`RCW_PLL_LOCK_CYC),
   parameter logic [`RCW_TMR_W-1:0] FAST_RC_SETTLE_CYC = `RCW_TMR_W'(`RCW_FAST_RC_SETTLE_CYC)
)(
   input  wire logic                 core_clk_i,
   input  wire logic                 rst_i,
   input  wire logic [7:0]           addr_i,
   input  wire logic [7:0]           wdata_i,
   input  wire logic                 wr_i,
   input  wire logic                 rd_i,
   input  wire logic [1:0]           brownout_mode_cfg_i,
   input  wire logic                 in_sleep_i,
   input  wire logic                 power_on_evt_i,
   input  wire logic                 pin_run_evt_i,
   input  wire logic                 pin_pm_evt_i,
   input  wire logic                 wdt_reset_evt_i,
   input  wire logic                 wdt_wake_evt_i,
   input  wire logic                 brownout_evt_i,
   input  wire logic                 reset_instr_evt_i,
   input  wire logic                 stack_full_evt_i,
   input  wire logic                 stack_under_evt_i,
   input  wire logic                 sleep_instr_i,
   input  wire logic                 clrwdt_instr_i,
   input  wire logic                 wake_reset_i,
   input  wire logic [1:0]           src_before_i,
   input  wire logic [2:0]           src_after_i,
   input  wire logic                 ost_ready_i,
   output logic      [7:0]           rdata_o,
   output logic                      cpu_exec_en_o,
   output logic                      primary_clock_ready_o,
   output logic                      fast_rc_stable_flag_o,
   output logic                      brownout_enable_o,
   output logic                      int_priority_enable_o,
   output logic      [3:0]           reset_cause_o,
   output logic      [2:0]           osc_sel_o
);

   localparam rcw_top_st_t ST_RST = '{
      int_priority_enable:  1'b0,
      soft_brownout_enable: 1'b1,
      reset_instr_flag:     1'b1,
      watchdog_expiry_flag: 1'b1,
      powerdown_flag:       1'b1,
      power_on_flag:        1'b0,
      brownout_flag:        1'b0,
      osc_sel:              `RCW_OSC_SEL_1MHZ,
      cause:                CAUSE_POWER_ON,
      brownout_on:          1'b0,
      wst:                  W_RUN,
      wake_dst:             DST_XTAL,
      exec_en:              1'b1,
      primary_clock_ready:  1'b0,
      fast_rc_stable_flag:  1'b0,
      ost_pend:             1'b0,
      pll_pend:             1'b0,
      settle_pend:          1'b0,
      rdata:                8'h00
   };

   rcw_top_st_t st_r;
   rcw_top_st_t st_nxt;
   logic        csd_start;
   logic        pll_start;
   logic        settle_start;
   logic        csd_busy;
   logic        pll_busy;
   logic        settle_busy;
   logic        ost_ready_s;

   // primary sources: crystal, crystal with pll, external rc or clock
   function automatic logic is_primary(input logic [2:0] dst);
      is_primary = (dst == DST_XTAL) || (dst == DST_XTAL_PLL) || (dst == DST_EXT_RC);
   endfunction

   // start-up timer only when a crystal restarts from a stopped primary
   function automatic logic needs_ost(input logic [1:0] src, input logic [2:0] dst);
      needs_ost = (src != SRC_PRIMARY) && ((dst == DST_XTAL) || (dst == DST_XTAL_PLL));
   endfunction

   rcw_sync u_ost_sync (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .async_i    (ost_ready_i),
      .level_o    (ost_ready_s)
   );

   rcw_wake_timer u_csd_tmr (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .start_i    (csd_start),
      .load_i     (`RCW_TMR_W'(`RCW_CPU_START_CYC)),
      .busy_o     (csd_busy)
   );

   rcw_wake_timer u_pll_tmr (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .start_i    (pll_start),
      .load_i     (PLL_LOCK_CYC),
      .busy_o     (pll_busy)
   );

   rcw_wake_timer u_settle_tmr (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .start_i    (settle_start),
      .load_i     (FAST_RC_SETTLE_CYC),
      .busy_o     (settle_busy)
   );

   always_comb begin
      st_nxt       = st_r;
      csd_start    = 1'b0;
      pll_start    = 1'b0;
      settle_start = 1'b0;

      // software writes; flags may be set or cleared here
      if (wr_i && (addr_i == `RCW_ADDR_RCC)) begin
         st_nxt.int_priority_enable  = wdata_i[`RCW_BIT_INT_PRIO];
         st_nxt.soft_brownout_enable = wdata_i[`RCW_BIT_SOFT_BROWNOUT];
         st_nxt.reset_instr_flag     = wdata_i[`RCW_BIT_RESET_INSTR];
         st_nxt.power_on_flag        = wdata_i[`RCW_BIT_POWER_ON];
         st_nxt.brownout_flag        = wdata_i[`RCW_BIT_BROWNOUT];
      end
      if (wr_i && (addr_i == `RCW_ADDR_WCTL)) begin
         st_nxt.osc_sel = wdata_i[2:0];
      end

      // hardware events come after the write so they win
      if (power_on_evt_i) begin
         st_nxt.power_on_flag        = 1'b0;
         st_nxt.watchdog_expiry_flag = 1'b1;
         st_nxt.powerdown_flag       = 1'b1;
      end
      if ((power_on_evt_i || brownout_evt_i) && st_r.brownout_on) begin
         st_nxt.brownout_flag = 1'b0;
      end
      if (reset_instr_evt_i) begin
         st_nxt.reset_instr_flag = 1'b0;
      end
      if (clrwdt_instr_i) begin
         st_nxt.watchdog_expiry_flag = 1'b1;
         st_nxt.powerdown_flag       = 1'b1;
      end
      if (sleep_instr_i) begin
         st_nxt.watchdog_expiry_flag = 1'b1;
         st_nxt.powerdown_flag       = 1'b0;
      end
      if (wdt_reset_evt_i || wdt_wake_evt_i) begin
         st_nxt.watchdog_expiry_flag = 1'b0;
      end

      // latest reset cause, power-on highest
      if (power_on_evt_i) begin
         st_nxt.cause = CAUSE_POWER_ON;
      end else if (pin_run_evt_i) begin
         st_nxt.cause = CAUSE_PIN_RUN;
      end else if (pin_pm_evt_i) begin
         st_nxt.cause = CAUSE_PIN_PM;
      end else if (wdt_reset_evt_i) begin
         st_nxt.cause = CAUSE_WDT;
      end else if (brownout_evt_i && st_r.brownout_on) begin
         st_nxt.cause = CAUSE_BROWNOUT;
      end else if (reset_instr_evt_i) begin
         st_nxt.cause = CAUSE_RESET_INSTR;
      end else if (stack_full_evt_i) begin
         st_nxt.cause = CAUSE_STACK_FULL;
      end else if (stack_under_evt_i) begin
         st_nxt.cause = CAUSE_STACK_UNDER;
      end

      // brown-out detector enable per configuration
      unique case (brownout_mode_cfg_i)
         `RCW_BROWNOUT_MODE_OFF:   st_nxt.brownout_on = 1'b0;
         `RCW_BROWNOUT_MODE_SW:    st_nxt.brownout_on = st_r.soft_brownout_enable;
         `RCW_BROWNOUT_MODE_SLEEP: st_nxt.brownout_on = !in_sleep_i;
         `RCW_BROWNOUT_MODE_HW:    st_nxt.brownout_on = 1'b1;
      endcase

      // exit delay sequencing
      unique case (st_r.wst)
         W_RUN: begin
         end
         W_HOLD: begin
            if (st_r.ost_pend && ost_ready_s) begin
               st_nxt.ost_pend = 1'b0;
            end
            if (!csd_busy && !st_r.ost_pend) begin
               if (st_r.pll_pend) begin
                  pll_start  = 1'b1;
                  st_nxt.wst = W_PLL;
               end else begin
                  st_nxt.wst                 = W_RUN;
                  st_nxt.exec_en             = 1'b1;
                  st_nxt.primary_clock_ready = is_primary(st_r.wake_dst);
               end
            end
         end
         W_PLL: begin
            if (!pll_busy) begin
               st_nxt.wst                 = W_RUN;
               st_nxt.exec_en             = 1'b1;
               st_nxt.primary_clock_ready = 1'b1;
               st_nxt.pll_pend            = 1'b0;
            end
         end
         default: begin
            st_nxt.wst = W_RUN;
         end
      endcase

      // fast oscillator settles in parallel with execution
      if (st_r.settle_pend && !settle_busy) begin
         st_nxt.fast_rc_stable_flag = 1'b1;
         st_nxt.settle_pend         = 1'b0;
      end

      // a reset wake restarts the whole exit delay
      if (wake_reset_i) begin
         csd_start                  = 1'b1;
         st_nxt.wst                 = W_HOLD;
         st_nxt.exec_en             = 1'b0;
         st_nxt.wake_dst            = rcw_src_after_t'(src_after_i);
         st_nxt.ost_pend            = needs_ost(src_before_i, src_after_i);
         st_nxt.pll_pend            = needs_ost(src_before_i, src_after_i) &&
                                      (src_after_i == DST_XTAL_PLL);
         st_nxt.primary_clock_ready = (src_before_i == SRC_PRIMARY) && is_primary(src_after_i);
         // the fast oscillator settles unless it was already the source before the wake
         if (src_after_i == DST_FAST_RC) begin
            if (src_before_i == SRC_FAST_RC) begin
               st_nxt.fast_rc_stable_flag = 1'b1;
               st_nxt.settle_pend         = 1'b0;
            end else begin
               st_nxt.fast_rc_stable_flag = 1'b0;
               st_nxt.settle_pend         = 1'b1;
               settle_start               = 1'b1;
            end
         end else begin
            st_nxt.fast_rc_stable_flag = 1'b0;
            st_nxt.settle_pend         = 1'b0;
         end
      end

      // read data stands only in the cycle after the strobe
      st_nxt.rdata = 8'h00;
      if (rd_i) begin
         case (addr_i)
            `RCW_ADDR_RCC: begin
               st_nxt.rdata = {st_r.int_priority_enable,
                               st_r.soft_brownout_enable &&
                               (brownout_mode_cfg_i == `RCW_BROWNOUT_MODE_SW),
                               1'b0,
                               st_r.reset_instr_flag,
                               st_r.watchdog_expiry_flag,
                               st_r.powerdown_flag,
                               st_r.power_on_flag,
                               st_r.brownout_flag};
            end
            `RCW_ADDR_WCTL: begin
               st_nxt.rdata = {5'h00, st_r.osc_sel};
            end
            `RCW_ADDR_WSTAT: begin
               st_nxt.rdata = {st_r.cause, st_r.settle_pend, st_r.fast_rc_stable_flag,
                               st_r.primary_clock_ready, st_r.exec_en};
            end
            default: begin
               st_nxt.rdata = 8'h00;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         st_r <= ST_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign rdata_o               = st_r.rdata;
   assign cpu_exec_en_o         = st_r.exec_en;
   assign primary_clock_ready_o = st_r.primary_clock_ready;
   assign fast_rc_stable_flag_o = st_r.fast_rc_stable_flag;
   assign brownout_enable_o     = st_r.brownout_on;
   assign int_priority_enable_o = st_r.int_priority_enable;
   assign reset_cause_o         = st_r.cause;
   assign osc_sel_o             = st_r.osc_sel;

   // checks
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (rst_i);

   localparam int CSD_LAST = `RCW_CPU_START_CYC + 1;

   sequence wake_plain_s;
      wake_reset_i && !needs_ost(src_before_i, src_after_i);
   endsequence
   sequence wake_settle_s;
      wake_reset_i && (src_after_i == DST_FAST_RC) && (src_before_i != SRC_FAST_RC);
   endsequence
   sequence pll_entry_s;
      (st_r.wst == W_HOLD) && (st_nxt.wst == W_PLL);
   endsequence

   csd_release_a: assert property (wake_plain_s |=> !cpu_exec_en_o ##CSD_LAST cpu_exec_en_o)
      else $error("cpu start delay length wrong");
   fast_settle_a: assert property (wake_settle_s |=> (!fast_rc_stable_flag_o ##CSD_LAST
                                   (cpu_exec_en_o && !fast_rc_stable_flag_o)))
      else $error("execution not released during oscillator settle");
   pll_hold_a: assert property (pll_entry_s |=> (!cpu_exec_en_o && !primary_clock_ready_o)[*8])
      else $error("execution released before pll lock");
   ost_hold_a: assert property (st_r.ost_pend && !ost_ready_s |=> !cpu_exec_en_o)
      else $error("execution released before start-up timer");
   fast_none_a: assert property (wake_reset_i && (src_after_i == DST_FAST_RC) &&
                                 (src_before_i == SRC_FAST_RC) |=> fast_rc_stable_flag_o)
      else $error("fast to fast wake lost stable flag");
   por_clear_a: assert property (power_on_evt_i |=> !st_r.power_on_flag)
      else $error("power-on flag not cleared");
   por_set_a: assert property ($rose(st_r.power_on_flag) |-> $past(wr_i) &&
                               $past(addr_i) == `RCW_ADDR_RCC && !$past(power_on_evt_i))
      else $error("power-on flag set without software");
   bor_clear_a: assert property ((power_on_evt_i || brownout_evt_i) && brownout_enable_o
                                 |=> !st_r.brownout_flag)
      else $error("brown-out flag not cleared");
   sbor_read_a: assert property (rd_i && addr_i == `RCW_ADDR_RCC &&
                                 brownout_mode_cfg_i != `RCW_BROWNOUT_MODE_SW |=> !rdata_o[6])
      else $error("software brown-out bit visible outside mode 01");
   bor_ctl_a: assert property (brownout_mode_cfg_i == `RCW_BROWNOUT_MODE_SW |=>
                               brownout_enable_o == $past(st_r.soft_brownout_enable))
      else $error("brown-out enable does not follow software bit");
   ri_clear_a: assert property (reset_instr_evt_i |=> !st_r.reset_instr_flag)
      else $error("reset instruction flag not cleared");
   sleep_flags_a: assert property (sleep_instr_i && !wdt_reset_evt_i && !wdt_wake_evt_i
                                   |=> !st_r.powerdown_flag && st_r.watchdog_expiry_flag)
      else $error("sleep did not update power-down flags");
   rst_dflt_a: assert property ($past(rst_i) |-> osc_sel_o == `RCW_OSC_SEL_1MHZ &&
                                !int_priority_enable_o && st_r.soft_brownout_enable)
      else $error("reset defaults wrong");

endmodule

//--- testbench/test_reset_cause_and_wake_delay.sv
// self-checking bench for the reset cause and wake delay block
// assumes rcw_reset_wake with shortened pll and settle counts
`timescale 1ns/1ns
`include "rcw_cfg.svh"
module test_reset_cause_and_wake_delay;
   logic        clk = 0, rst = 1, wr = 0, rd = 0, wk = 0, ost = 0, slp = 0;
   logic [7:0]  adr = 0, wd = 0, rdat;
   logic [1:0]  md = 2'h1, sb = 0;
   logic [2:0]  sa = 0, os;
   logic [10:0] ev = 0;
   logic        ex, pr, fs, be, ip;
   logic [3:0]  ca;
   int          num_errors = 0, cmp_count = 0, cyc = 0;

   rcw_reset_wake #(.PLL_LOCK_CYC(16'h0014), .FAST_RC_SETTLE_CYC(16'h0050)) i_dut (
      .core_clk_i(clk), .rst_i(rst), .addr_i(adr), .wdata_i(wd), .wr_i(wr), .rd_i(rd),
      .brownout_mode_cfg_i(md), .in_sleep_i(slp), .power_on_evt_i(ev[0]), .pin_run_evt_i(ev[1]),
      .pin_pm_evt_i(ev[2]), .wdt_reset_evt_i(ev[3]), .wdt_wake_evt_i(ev[4]), .brownout_evt_i(ev[5]),
      .reset_instr_evt_i(ev[6]), .stack_full_evt_i(ev[7]), .stack_under_evt_i(ev[8]),
      .sleep_instr_i(ev[9]), .clrwdt_instr_i(ev[10]), .wake_reset_i(wk), .src_before_i(sb),
      .src_after_i(sa), .ost_ready_i(ost), .rdata_o(rdat), .cpu_exec_en_o(ex),
      .primary_clock_ready_o(pr), .fast_rc_stable_flag_o(fs), .brownout_enable_o(be),
      .int_priority_enable_o(ip), .reset_cause_o(ca), .osc_sel_o(os));

   always #20 clk = ~clk;

   task automatic end_sim();
      $display("checks %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cyc++;
      if (cyc == 6000) begin
         num_errors++;
         end_sim();
      end
   end

   task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
      cmp_count++;
      if (s !== e) begin
         num_errors++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      adr <= a;
      wd <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rreg(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      adr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk("register", rdat, e);
   endtask

   task automatic pulse(input int i);
      @(posedge clk);
      ev[i] <= 1'b1;
      @(posedge clk);
      ev <= '0;
      #1;
   endtask

   task automatic wake(input logic [1:0] b, input logic [2:0] s, input int n);
      @(posedge clk);
      wk <= 1'b1;
      sb <= b;
      sa <= s;
      @(posedge clk);
      wk <= 1'b0;
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic t_reset();
      rreg(8'h00, 8'h5C);
      rreg(8'h01, 8'h04);
      @(posedge clk);
      #1 chk("rdata_idle", rdat, 8'h00);
      chk("osc_sel", 8'(os), 8'h04);
      chk("int_prio", 8'(ip), 8'h00);
      $display("test reset done");
   endtask

   task automatic t_flags();
      wreg(8'h00, 8'hFF);
      rreg(8'h00, 8'hDF);
      pulse(6);
      rreg(8'h00, 8'hCF);
      chk("cause", 8'(ca), 8'h06);
      pulse(0);
      rreg(8'h00, 8'hCC);
      pulse(9);
      rreg(8'h00, 8'hC8);
      pulse(3);
      rreg(8'h00, 8'hC0);
      pulse(10);
      rreg(8'h00, 8'hCC);
      pulse(4);
      rreg(8'h00, 8'hC4);
      pulse(10);
      rreg(8'h00, 8'hCC);
      $display("test flags done");
   endtask

   task automatic t_mode();
      @(posedge clk);
      md <= 2'h0;
      wreg(8'h00, 8'h03);
      rreg(8'h00, 8'h0F);
      chk("bo_en", 8'(be), 8'h00);
      pulse(5);
      rreg(8'h00, 8'h0F);
      @(posedge clk);
      md <= 2'h1;
      wreg(8'h00, 8'h43);
      @(posedge clk);
      #1 chk("bo_en", 8'(be), 8'h01);
      pulse(5);
      rreg(8'h00, 8'h4E);
      chk("cause", 8'(ca), 8'h05);
      @(posedge clk);
      md <= 2'h3;
      repeat (2) @(posedge clk);
      #1 chk("bo_en", 8'(be), 8'h01);
      rreg(8'h00, 8'h0E);
      @(posedge clk);
      md <= 2'h2;
      slp <= 1'b1;
      repeat (2) @(posedge clk);
      #1 chk("bo_en", 8'(be), 8'h00);
      @(posedge clk);
      md <= 2'h1;
      slp <= 1'b0;
      $display("test mode done");
   endtask

   task automatic t_cause();
      int idx[5] = '{1, 2, 3, 7, 8};
      logic [7:0] code[5] = '{8'h02, 8'h03, 8'h04, 8'h07, 8'h08};
      for (int k = 0; k < 5; k++) begin
         pulse(idx[k]);
         chk("cause", 8'(ca), code[k]);
      end
      $display("test cause done");
   endtask

   task automatic t_wake();
      wake(2'h3, 3'h2, 1);
      chk("exec", 8'(ex), 8'h00);
      repeat (49) @(posedge clk);
      #1 chk("exec", 8'(ex), 8'h00);
      @(posedge clk);
      #1 chk("exec", 8'(ex), 8'h01);
      chk("pri_rdy", 8'(pr), 8'h01);
      rreg(8'h02, 8'h83);
      wake(2'h3, 3'h4, 1);
      chk("rc_stab", 8'(fs), 8'h00);
      chk("pri_rdy", 8'(pr), 8'h00);
      repeat (79) @(posedge clk);
      #1 chk("exec", 8'(ex), 8'h01);
      chk("rc_stab", 8'(fs), 8'h00);
      @(posedge clk);
      #1 chk("rc_stab", 8'(fs), 8'h01);
      wake(2'h2, 3'h4, 1);
      chk("rc_stab", 8'(fs), 8'h01);
      repeat (50) @(posedge clk);
      #1 chk("exec", 8'(ex), 8'h01);
      $display("test wake done");
   endtask

   task automatic t_pll();
      wake(2'h3, 3'h1, 1);
      chk("exec", 8'(ex), 8'h00);
      chk("pri_rdy", 8'(pr), 8'h00);
      repeat (60) @(posedge clk);
      #1 chk("exec", 8'(ex), 8'h00);
      @(posedge clk);
      ost <= 1'b1;
      repeat (26) @(posedge clk);
      #1 chk("exec", 8'(ex), 8'h00);
      @(posedge clk);
      #1 chk("exec", 8'(ex), 8'h01);
      chk("pri_rdy", 8'(pr), 8'h01);
      $display("test pll done");
   endtask

   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_flags();
      t_mode();
      t_cause();
      t_wake();
      t_pll();
      end_sim();
   end
endmodule
